/* File: inc/sdm_defs.vh */
/*
 * constants for the step/dir microstep sequencer: register offsets,
 * field positions, reset values and timing counts.
 * assumes a 100 MHz core clock.
 */
`ifndef SDM_DEFS_VH
`define SDM_DEFS_VH

// register offsets (byte addresses, one 32-bit word each)
`define SDM_REG_CTRL      8'h00
`define SDM_REG_VELOCITY  8'h04
`define SDM_REG_STATUS    8'h08
`define SDM_REG_COUNTER   8'h0C
`define SDM_REG_COILS     8'h10
`define SDM_REG_SERIAL    8'h14

// control register fields
`define SDM_CTRL_DUAL_EDGE_SELECT_BIT     0
`define SDM_CTRL_PINDIS_BIT    1
`define SDM_CTRL_MRES_LSB      4
`define SDM_CTRL_MRES_MSB      7
`define SDM_CTRL_ADDR_LSB      8
`define SDM_CTRL_ADDR_MSB      9
`define SDM_CTRL_RESET         32'h00000000

// resolution codes: 0 = 256 microsteps ... 8 = fullstep
`define SDM_MRES_256           4'h0
`define SDM_MRES_FULL          4'h8

// microstep counter spans four fullsteps
`define SDM_CNT_W              10

// serial activity: bit time limits for 9600..500k baud at 100 MHz
`define SDM_BAUD_MIN_BAUD      9600
`define SDM_BAUD_MAX_BAUD      500000
`define SDM_CLK_HZ             100000000
`define SDM_BIT_MAX_CYC        (`SDM_CLK_HZ / `SDM_BAUD_MIN_BAUD)
`define SDM_BIT_MIN_CYC        (`SDM_CLK_HZ / `SDM_BAUD_MAX_BAUD)

// index pulse length in cycles
`define SDM_INDEX_CYC          8'h04

// velocity accumulator width
`define SDM_ACC_W              24

`endif

/* File: verilog/sdm_sequencer.v */
/*
 * step/dir front end of a two-phase stepper driver: microstep counter,
 * sine/cosine table, internal velocity pulse generator, pin or register
 * resolution select, index and fault outputs, serial activity detection.
 * assumes all inputs synchronous to CLK, registers reached over a plain
 * address/strobe port with read data one cycle after the read strobe.
 */
// The register offsets and the address-and-strobe port were left to the implementer.
`include "sdm_defs.vh"

module sdm_sequencer #(
    parameter CNT_W = `SDM_CNT_W,
    parameter ACC_W = `SDM_ACC_W
) (
    input wire CLK,
    input wire SYS_RST,
    input wire CE,
    input wire STEP,
    input wire DIR,
    input wire DRIVE_ENABLE_N,
    input wire RESOLUTION_SELECT_0,
    input wire RESOLUTION_SELECT_1,
    input wire POWERDOWN_SERIAL_PIN,
    input wire DRIVER_ERROR,
    input wire STALL_DETECT,
    input wire [7:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    output reg [CNT_W-1:0] MICROSTEP_COUNTER,
    output reg signed [8:0] COIL_A,
    output reg signed [8:0] COIL_B,
    output reg POWER_STAGE_ON,
    output reg STANDSTILL_REDUCE,
    output reg INDEX_OUT,
    output reg FAULT_INDICATOR_OUT
);

    // ****************************************
    // registers
    // ****************************************
    reg [31:0] ctrl_r;
    reg signed [ACC_W-1:0] velocity_r;
    reg [ACC_W-1:0] accum_r;
    reg step_d_r;
    reg fault_r;
    reg serial_on_r;
    reg serial_d_r;
    reg [15:0] low_cnt_r;
    reg [15:0] bit_time_r;
    reg [7:0] index_cnt_r;
    reg [CNT_W-1:0] cnt_nxt;

    wire dual_edge_select = ctrl_r[`SDM_CTRL_DUAL_EDGE_SELECT_BIT];
    wire pin_disable = ctrl_r[`SDM_CTRL_PINDIS_BIT];
    wire [3:0] reg_mres = ctrl_r[`SDM_CTRL_MRES_MSB:`SDM_CTRL_MRES_LSB];
    wire [1:0] slave_addr = ctrl_r[`SDM_CTRL_ADDR_MSB:`SDM_CTRL_ADDR_LSB];

    // ****************************************
    // resolution select
    // ****************************************
    reg [3:0] pin_mres;
    always @* begin
        case ({RESOLUTION_SELECT_1, RESOLUTION_SELECT_0})
            2'b00: pin_mres = 4'h5;   // 8
            2'b01: pin_mres = 4'h3;   // 32
            2'b10: pin_mres = 4'h2;   // 64
            default: pin_mres = 4'h4; // 16
        endcase
    end

    // register resolution only takes over once serial is live and pins disabled
    wire use_reg = serial_on_r & pin_disable;
    wire [3:0] mres_raw = use_reg ? reg_mres : pin_mres;
    wire [3:0] mres = (mres_raw > `SDM_MRES_FULL) ? `SDM_MRES_FULL : mres_raw;
    wire [CNT_W-1:0] step_inc = {{(CNT_W-1){1'b0}}, 1'b1} << mres;

    // ****************************************
    // step sources
    // ****************************************
    wire rise = STEP & ~step_d_r;
    wire fall = ~STEP & step_d_r;
    wire ext_step = rise | (dual_edge_select & fall);

    // velocity magnitude; sign picks the direction, no ramp applied
    wire vel_neg = velocity_r[ACC_W-1];
    wire [ACC_W-1:0] vel_mag = vel_neg ? (~velocity_r + 1'b1) : velocity_r;
    wire [ACC_W:0] acc_sum = {1'b0, accum_r} + {1'b0, vel_mag};
    wire int_step = acc_sum[ACC_W];

    // ****************************************
    // counter update
    // ****************************************
    always @* begin
        cnt_nxt = MICROSTEP_COUNTER;
        // both sources may fire together; each moves independently
        if (ext_step) begin
            if (DIR)
                cnt_nxt = cnt_nxt - step_inc;
            else
                cnt_nxt = cnt_nxt + step_inc;
        end
        if (int_step) begin
            if (vel_neg)
                cnt_nxt = cnt_nxt - step_inc;
            else
                cnt_nxt = cnt_nxt + step_inc;
        end
    end

    // ****************************************
    // quarter-wave sine table
    // ****************************************
    function [7:0] qsin;
        input [7:0] ph;
        reg [15:0] x;
        reg [31:0] y;
        begin
            // parabolic approximation 4x(1-x) on a quarter period
            // no offset here, so the table starts at zero and the coil current is nil there
            x = {8'h00, ph};
            y = {16'h0000, x} * ({16'h0000, 16'h0200} - {16'h0000, x});
            qsin = (y[31:8] > 24'h0000FF) ? 8'hFF : y[15:8];
        end
    endfunction

    function signed [8:0] wave;
        input [CNT_W-1:0] c;
        reg [7:0] m;
        begin
            m = c[8] ? qsin(8'hFF - c[7:0]) : qsin(c[7:0]);
            wave = c[9] ? -$signed({1'b0, m}) : $signed({1'b0, m});
        end
    endfunction

    // ****************************************
    // serial activity and baud detect
    // ****************************************
    // a low pulse whose width lies inside the legal bit time range
    // counts as well formed traffic and switches the port on
    wire rx_rise = POWERDOWN_SERIAL_PIN & ~serial_d_r;
    wire pulse_ok = (low_cnt_r >= `SDM_BIT_MIN_CYC) && (low_cnt_r <= `SDM_BIT_MAX_CYC);

    // ****************************************
    // main clocked process
    // ****************************************
    always @(posedge CLK) begin
        if (SYS_RST) begin
            ctrl_r <= `SDM_CTRL_RESET;
            velocity_r <= {ACC_W{1'b0}};
            accum_r <= {ACC_W{1'b0}};
            step_d_r <= 1'b0;
            fault_r <= 1'b0;
            serial_on_r <= 1'b0;
            serial_d_r <= 1'b1;
            low_cnt_r <= 16'h0000;
            bit_time_r <= 16'h0000;
            index_cnt_r <= 8'h00;
            MICROSTEP_COUNTER <= {CNT_W{1'b0}};
            COIL_A <= 9'h000;
            COIL_B <= 9'h000;
            POWER_STAGE_ON <= 1'b0;
            STANDSTILL_REDUCE <= 1'b0;
            INDEX_OUT <= 1'b0;
            FAULT_INDICATOR_OUT <= 1'b0;
            RDATA <= 32'h00000000;
        end else if (CE) begin
            step_d_r <= STEP;
            accum_r <= acc_sum[ACC_W-1:0];
            MICROSTEP_COUNTER <= cnt_nxt;
            COIL_A <= wave(cnt_nxt);
            COIL_B <= wave(cnt_nxt + 10'h100);
            POWER_STAGE_ON <= ~DRIVE_ENABLE_N;
            // without serial use the pin level picks standstill reduction
            STANDSTILL_REDUCE <= serial_on_r ? 1'b1 : ~POWERDOWN_SERIAL_PIN;

            // event set wins over the enable clear
            if (DRIVER_ERROR | STALL_DETECT)
                fault_r <= 1'b1;
            else if (DRIVE_ENABLE_N)
                fault_r <= 1'b0;
            FAULT_INDICATOR_OUT <= fault_r | DRIVER_ERROR | STALL_DETECT;

            if (cnt_nxt[CNT_W-1:0] == {CNT_W{1'b0}} && cnt_nxt != MICROSTEP_COUNTER)
                index_cnt_r <= `SDM_INDEX_CYC;
            else if (index_cnt_r != 8'h00)
                index_cnt_r <= index_cnt_r - 8'h01;
            INDEX_OUT <= (index_cnt_r != 8'h00);

            serial_d_r <= POWERDOWN_SERIAL_PIN;
            if (!POWERDOWN_SERIAL_PIN) begin
                if (low_cnt_r != 16'hFFFF)
                    low_cnt_r <= low_cnt_r + 16'h0001;
            end else begin
                low_cnt_r <= 16'h0000;
            end
            if (rx_rise && pulse_ok) begin
                serial_on_r <= 1'b1;
                bit_time_r <= low_cnt_r;
            end

            RDATA <= 32'h00000000;
            if (WR) begin
                case (ADDR)
                    `SDM_REG_CTRL: ctrl_r <= WDATA;
                    `SDM_REG_VELOCITY: velocity_r <= WDATA[ACC_W-1:0];
                    default: ;
                endcase
            end
            if (RD) begin
                case (ADDR)
                    `SDM_REG_CTRL: RDATA <= ctrl_r;
                    `SDM_REG_VELOCITY: RDATA <= {{(32-ACC_W){velocity_r[ACC_W-1]}}, velocity_r};
                    `SDM_REG_STATUS: RDATA <= {26'h0, slave_addr, use_reg, serial_on_r,
                                               fault_r, ~DRIVE_ENABLE_N};
                    `SDM_REG_COUNTER: RDATA <= {{(32-CNT_W){1'b0}}, MICROSTEP_COUNTER};
                    `SDM_REG_COILS: RDATA <= {7'h00, COIL_B, 7'h00, COIL_A};
                    `SDM_REG_SERIAL: RDATA <= {16'h0000, bit_time_r};
                    default: RDATA <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

/* File: verif/sdm_host_model.sv */
/* host side model: step/dir edges and serial line low pulses.
   assumes requests come from the bench one clock apart or more. */
module sdm_host_model (
    input wire logic clk,
    input wire logic step_req,
    input wire logic dir_req,
    input wire logic ser_req,
    input wire logic [15:0] ser_len,
    output logic step,
    output logic dir,
    output logic ser_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] low_cnt = 16'h0000;
    initial begin
        step = 1'b0;
        dir = 1'b0;
    end
    // write-only use, no read-back: no checksum check, no shadow copy
    always @(posedge clk) begin
        if (step_req) begin
            step <= ~step;
            dir <= dir_req;
        end
        if (ser_req)
            low_cnt <= ser_len;
        else if (low_cnt != 16'h0000)
            low_cnt <= low_cnt - 16'h0001;
    end
    // line rests at its pull-up level between pulses
    assign ser_line = (low_cnt == 16'h0000);
endmodule

/* File: verif/sdm_sequencer_sva.sv */
/* port assertions for the sequencer.
   assumes CE held high throughout. */
module sdm_sequencer_sva #(
    parameter CNT_W = 10
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic DRIVE_ENABLE_N,
    input wire logic POWERDOWN_SERIAL_PIN,
    input wire logic DRIVER_ERROR,
    input wire logic STALL_DETECT,
    input wire logic [7:0] ADDR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic [CNT_W-1:0] MICROSTEP_COUNTER,
    input wire logic POWER_STAGE_ON,
    input wire logic STANDSTILL_REDUCE,
    input wire logic INDEX_OUT,
    input wire logic FAULT_INDICATOR_OUT
);
    // ****************
    // checks
    // ****************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    property p_pwr; !$past(SYS_RST) && !$past(SYS_RST, 2) |-> POWER_STAGE_ON == !$past(DRIVE_ENABLE_N); endproperty
    a_pwr: assert property (p_pwr) else $error("power stage not following enable");
    property p_reduce; !$past(SYS_RST) && !POWERDOWN_SERIAL_PIN |=> STANDSTILL_REDUCE; endproperty
    a_reduce: assert property (p_reduce) else $error("low pin without standstill reduction");
    property p_fset; DRIVER_ERROR || STALL_DETECT |=> FAULT_INDICATOR_OUT; endproperty
    a_fset: assert property (p_fset) else $error("fault output missed an error");
    property p_fclr; (DRIVE_ENABLE_N && !DRIVER_ERROR && !STALL_DETECT) [*2] |=> !FAULT_INDICATOR_OUT; endproperty
    a_fclr: assert property (p_fclr) else $error("fault not cleared by enable high");
    property p_idx_len; $rose(INDEX_OUT) |-> INDEX_OUT [*4] ##1 !INDEX_OUT; endproperty
    a_idx_len: assert property (p_idx_len) else $error("index pulse length wrong");
    property p_idx_zero; $rose(INDEX_OUT) |-> MICROSTEP_COUNTER == 0 || $past(MICROSTEP_COUNTER) == 0; endproperty
    a_idx_zero: assert property (p_idx_zero) else $error("index away from zero");
    property p_delta; !$past(SYS_RST) && MICROSTEP_COUNTER != $past(MICROSTEP_COUNTER) |->
        $onehot(CNT_W'(MICROSTEP_COUNTER - $past(MICROSTEP_COUNTER))) ||
        $onehot(CNT_W'($past(MICROSTEP_COUNTER) - MICROSTEP_COUNTER)); endproperty
    a_delta: assert property (p_delta) else $error("counter moved by odd amount");
    property p_rd_cnt; RD && ADDR == 8'h0C |=> RDATA[CNT_W-1:0] == $past(MICROSTEP_COUNTER); endproperty
    a_rd_cnt: assert property (p_rd_cnt) else $error("counter read mismatch");
endmodule
bind sdm_sequencer sdm_sequencer_sva #(.CNT_W(CNT_W)) u_sdm_sequencer_sva (.CLK(CLK), .SYS_RST(SYS_RST),
    .DRIVE_ENABLE_N(DRIVE_ENABLE_N), .POWERDOWN_SERIAL_PIN(POWERDOWN_SERIAL_PIN), .DRIVER_ERROR(DRIVER_ERROR),
    .STALL_DETECT(STALL_DETECT), .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .MICROSTEP_COUNTER(MICROSTEP_COUNTER),
    .POWER_STAGE_ON(POWER_STAGE_ON), .STANDSTILL_REDUCE(STANDSTILL_REDUCE), .INDEX_OUT(INDEX_OUT),
    .FAULT_INDICATOR_OUT(FAULT_INDICATOR_OUT));

/* File: verif/sdm_sequencer_test.sv */
/* self-checking bench for the step/dir sequencer.
   assumes the host model drives step, dir and the serial line. */
`include "sdm_defs.vh"
module sdm_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, sys_rst = 1'b1, drive_enable_n = 1'b0, ms0 = 1'b0, ms1 = 1'b0, err = 1'b0, stall = 1'b0;
    logic wr_s = 1'b0, rd_s = 1'b0, step_req = 1'b0, dir_req = 1'b0, ser_req = 1'b0, step, dir, ser;
    logic pwr, reduce, idx, idx_q = 1'b0, fault;
    logic [7:0] addr = 8'h00;
    logic [15:0] ser_len = 16'h0000;
    logic [31:0] wdata = 32'h00000000, rdata, d;
    logic [9:0] cnt, c1, exp_cnt = 10'h000;
    logic signed [8:0] coil_a;
    int bad_count = 0, n_checks = 0, idx_n = 0, inc;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        idx_q <= idx;
        if (idx && !idx_q)
            idx_n <= idx_n + 1;
    end
    // ****************
    // design and host
    // ****************
    sdm_sequencer u_sdm_sequencer (.CLK(clk), .SYS_RST(sys_rst), .CE(1'b1), .STEP(step), .DIR(dir),
        .DRIVE_ENABLE_N(drive_enable_n), .RESOLUTION_SELECT_0(ms0), .RESOLUTION_SELECT_1(ms1), .POWERDOWN_SERIAL_PIN(ser),
        .DRIVER_ERROR(err), .STALL_DETECT(stall), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
        .RDATA(rdata), .MICROSTEP_COUNTER(cnt), .COIL_A(coil_a), .COIL_B(), .POWER_STAGE_ON(pwr),
        .STANDSTILL_REDUCE(reduce), .INDEX_OUT(idx), .FAULT_INDICATOR_OUT(fault));
    sdm_host_model u_sdm_host_model (.clk(clk), .step_req(step_req), .dir_req(dir_req), .ser_req(ser_req),
        .ser_len(ser_len), .step(step), .dir(dir), .ser_line(ser));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic stp(input logic dn, input int n);
        @(posedge clk);
        step_req <= 1'b1;
        dir_req <= dn;
        @(posedge clk);
        step_req <= 1'b0;
        exp_cnt = dn ? exp_cnt - 10'(n) : exp_cnt + 10'(n);
        tick(2);
        #1 chk("counter", {22'h0, exp_cnt}, {22'h0, cnt});
    endtask
    task automatic ser_pulse(input logic [15:0] n);
        @(posedge clk);
        ser_req <= 1'b1;
        ser_len <= n;
        @(posedge clk);
        ser_req <= 1'b0;
        tick(n + 4);
    endtask
    task automatic flt(input logic s);
        @(posedge clk);
        err <= !s;
        stall <= s;
        @(posedge clk);
        err <= 1'b0;
        stall <= 1'b0;
        tick(4);
        #1 chk("fault set", 1, fault);
        @(posedge clk);
        drive_enable_n <= 1'b1;
        tick(3);
        #1 chk("fault clear", 0, fault);
        chk("power off", 0, pwr);
        @(posedge clk);
        drive_enable_n <= 1'b0;
        tick(2);
        #1 chk("power on", 1, pwr);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        tick(20000);
        bad_count++;
        conclude();
    end
    // ****************
    // test sequence
    // ****************
    initial begin
        tick(16);
        sys_rst <= 1'b0;
        tick(2);
        rd(`SDM_REG_CTRL);
        chk("ctrl reset", `SDM_CTRL_RESET, d);
        rd(8'hFC);
        chk("unmapped read", 0, d);
        chk("reduce off", 0, reduce);
        for (int i = 0; i < 4; i++) begin
            inc = (i == 0) ? 32 : (i == 1) ? 8 : (i == 2) ? 4 : 16;
            @(posedge clk);
            {ms1, ms0} <= i[1:0];
            stp(1'b1, inc);
            stp(1'b0, 0);
            stp(1'b0, inc);
            stp(1'b1, 0);
        end
        chk("index pulses", 4, idx_n);
        chk("coil at zero", 0, {23'h0, coil_a});
        rd(`SDM_REG_COUNTER);
        chk("counter read", {22'h0, exp_cnt}, d);
        rd(`SDM_REG_COILS);
        chk("coils at zero", 32'h00FF0000, d);
        ser_pulse(16'h0064);
        rd(`SDM_REG_STATUS);
        chk("short pulse", 1, d);
        ser_pulse(16'h03E8);
        wr(`SDM_REG_CTRL, 32'h00000383);
        rd(`SDM_REG_STATUS);
        chk("status", 32'h0000003D, d);
        chk("reduce on", 1, reduce);
        for (int m = 0; m < 9; m++) begin
            wr(`SDM_REG_CTRL, 32'h00000303 | (m << 4));
            stp(1'b0, 1 << m);
            stp(1'b1, 1 << m);
        end
        // no ramp: velocity steps stay small enough to apply at once
        wr(`SDM_REG_CTRL, 32'h00000303);
        wr(`SDM_REG_VELOCITY, 32'h00100000);
        tick(160);
        wr(`SDM_REG_VELOCITY, 32'h00000000);
        tick(2);
        c1 = cnt;
        chk("velocity forward", 1, c1 inside {[10'h009:10'h00B]});
        wr(`SDM_REG_VELOCITY, 32'h00F00000);
        tick(160);
        wr(`SDM_REG_VELOCITY, 32'h00000000);
        tick(2);
        chk("velocity reverse", 1, 10'(c1 - cnt) inside {[10'h009:10'h00B]});
        flt(1'b0);
        flt(1'b1);
        conclude();
    end
endmodule
